// *** verilog/sai_pkg.sv ***
// Shared constants and carrier types of the serial converter control block
package sai_pkg;

    // ------------------------------------------------------------
    // Widths and counts
    // ------------------------------------------------------------
    localparam int ADDR_BITS = 4;
    localparam int RES_BITS = 10;
    localparam int NUM_CH = 14;
    localparam int NUM_EXT = 11;
    localparam int EDGE_W = 5;

    // ------------------------------------------------------------
    // Serial clock edge numbers
    // ------------------------------------------------------------
    localparam logic [EDGE_W-1:0] ADDR_EDGES = 5'h04;
    localparam logic [EDGE_W-1:0] SAMPLE_EDGE = 5'h04;
    localparam logic [EDGE_W-1:0] LAST_EDGE = 5'h0A;
    localparam logic [EDGE_W-1:0] MAX_EDGES = 5'h10;
    localparam logic [EDGE_W-1:0] EDGE_ONE = 5'h01;
    localparam logic [EDGE_W-1:0] EDGE_ZERO = 5'h00;

    // ------------------------------------------------------------
    // Reset values and sequencer constants
    // ------------------------------------------------------------
    localparam logic [RES_BITS-1:0] RESULT_RST = 10'h000;
    localparam logic [RES_BITS-1:0] TRIAL_MSB = 10'h200;
    localparam logic [ADDR_BITS-1:0] CODE_RST = 4'h0;
    localparam logic [3:0] BIT_LAST = 4'h0;
    localparam logic [3:0] BIT_FIRST = 4'h9;
    localparam logic [3:0] BIT_STEP = 4'h1;
    localparam logic [2:0] PIN_RST = 3'h4;

    // ------------------------------------------------------------
    // Carrier types and states
    // ------------------------------------------------------------
    typedef struct packed {
        logic csN;
        logic sclk;
        logic addr;
    } sai_pins_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SAMPLE = 2'b01,
        ST_CONV = 2'b11,
        ST_DONE = 2'b10
    } sai_state_t;

endpackage

// *** verilog/sai_sync.sv ***
// Three-stage pin synchroniser with agreement filter, one lane per bit
`timescale 1ns/1ps
`default_nettype none

module sai_sync #(
    parameter int WIDTH = 3,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] rawIn,
    output logic [WIDTH-1:0] levelOut
);

    // ------------------------------------------------------------
    // Per-bit lanes
    // ------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : gLane
            logic s1_q, s2_q, s3_q, lvl_q;
            logic lvl_d;

            // Stage one feeds stage two only; a change counts once two and three agree
            always_comb begin
                lvl_d = lvl_q;
                if (s2_q == s3_q) begin
                    lvl_d = s3_q;
                end
            end

            // Reset to the idle pin level so no false edge shows after release
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    s1_q <= RST_VAL[i];
                    s2_q <= RST_VAL[i];
                    s3_q <= RST_VAL[i];
                    lvl_q <= RST_VAL[i];
                end else begin
                    s1_q <= rawIn[i];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                    lvl_q <= lvl_d;
                end
            end

            assign levelOut[i] = lvl_q;
        end
    endgenerate

endmodule

`default_nettype wire

// *** verilog/sai_core.sv ***
// Serial control, result shift-out and conversion sequencer of the converter
//
// How it works
// RULE1 - A 4-bit channel code is taken each transfer and picks the input for the next conversion.
// RULE2 - Code bits arrive MSB first, one on each of the first four serial clock rising edges after select falls.
// RULE3 - After four code bits the address pin is ignored for the rest of the conversion period.
// RULE4 - A falling select clears counters and control state and enables output, address and clock within two cycles; here this takes five system clocks.
// RULE5 - A rising select stops address and clock being accepted within the same short delay.
// RULE6 - The result pin is released while select is high and driven while select is low.
// RULE7 - Once select is low the result pin carries the MSB of the last finished conversion before any falling edge.
// RULE8 - Each serial clock falling edge moves out the next lower bit, the LSB on the ninth.
// RULE9 - From the tenth falling edge the result pin is held low so extra clocks read zeros.
// RULE10 - A 14-way selector covers 11 external inputs and three test voltages, chosen by the code.
// RULE11 - End of conversion goes high when a conversion finishes and its result is ready.
// RULE12 - The link is four wires: select, serial clock and address in, three-state result out.
// RULE13 - End of conversion goes low at the tenth falling edge and stays low until the result is ready.
// RULE14 - Sampling runs from the fourth falling edge to the tenth.
// RULE15 - At the tenth falling edge the internal sequencer on the system clock takes over the conversion.
// RULE16 - The host gives 10 to 16 serial clocks per transfer, ten at least for a conversion.
// RULE17 - The host samples each result bit on the rising edge after the falling edge that showed it; the bench host samples late in the high phase instead.
`timescale 1ns/1ps
`default_nettype none

module sai_core
    import sai_pkg::*;
#(
    parameter int CH_COUNT = NUM_CH
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic chipSelectN,
    input wire logic serialClock,
    input wire logic serialAddress,
    input wire logic compHigh,
    output logic dataOut,
    output logic dataOutEn,
    output logic endOfConv,
    output logic sampleEn,
    output logic [CH_COUNT-1:0] analogSel,
    output logic [RES_BITS-1:0] dacTrial
);

    // ------------------------------------------------------------
    // Pin synchronisers and edge detection
    // ------------------------------------------------------------
    sai_pins_t pinRaw, pinLvl, pinPrev_q;
    logic csActive, csFall, sclkRise, sclkFall;

    assign pinRaw.csN = chipSelectN; // RULE12
    assign pinRaw.sclk = serialClock;
    assign pinRaw.addr = serialAddress;

    sai_sync #(
        .WIDTH(3),
        .RST_VAL(PIN_RST)
    ) uSync (
        .clk(clk),
        .resetn(resetn),
        .rawIn(pinRaw),
        .levelOut(pinLvl)
    );

    // Previous filtered level, for edge finding on the system clock
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pinPrev_q <= PIN_RST;
        end else begin
            pinPrev_q <= pinLvl;
        end
    end

    // Clock and address only count while select is low
    assign csActive = !pinLvl.csN; // RULE5
    assign csFall = pinPrev_q.csN && !pinLvl.csN; // RULE4
    assign sclkRise = csActive && !pinPrev_q.sclk && pinLvl.sclk;
    assign sclkFall = csActive && pinPrev_q.sclk && !pinLvl.sclk;

    // ------------------------------------------------------------
    // Transfer and conversion state
    // ------------------------------------------------------------
    sai_state_t state_q, state_d;
    logic [EDGE_W-1:0] riseCnt_q, riseCnt_d, fallCnt_q, fallCnt_d;
    logic [ADDR_BITS-1:0] addrShift_q, addrShift_d, chanCode_q, chanCode_d;
    logic [RES_BITS-1:0] outShift_q, outShift_d, lastResult_q, lastResult_d;
    logic [RES_BITS-1:0] dac_q, dac_d;
    logic [3:0] bitIdx_q, bitIdx_d;
    logic dataOut_q, dataOut_d, dataOutEn_q, dataOutEn_d;
    logic eoc_q, eoc_d, sampleEn_q, sampleEn_d;
    logic [EDGE_W-1:0] fallNext;

    assign fallNext = fallCnt_q + EDGE_ONE;

    // Next-state logic; select falling outranks every other event
    always_comb begin
        state_d = state_q;
        riseCnt_d = riseCnt_q;
        fallCnt_d = fallCnt_q;
        addrShift_d = addrShift_q;
        chanCode_d = chanCode_q;
        outShift_d = outShift_q;
        lastResult_d = lastResult_q;
        dac_d = dac_q;
        bitIdx_d = bitIdx_q;
        dataOut_d = dataOut_q;
        eoc_d = eoc_q;
        sampleEn_d = sampleEn_q;
        dataOutEn_d = csActive; // RULE6

        // Address capture, MSB first, closed after the fourth rising edge
        if (sclkRise && (riseCnt_q < ADDR_EDGES)) begin // RULE2 RULE3
            addrShift_d = {addrShift_q[ADDR_BITS-2:0], pinLvl.addr};
            riseCnt_d = riseCnt_q + EDGE_ONE;
            if (riseCnt_q == ADDR_EDGES - EDGE_ONE) begin
                chanCode_d = {addrShift_q[ADDR_BITS-2:0], pinLvl.addr}; // RULE1
            end
        end

        // Result shift-out; zeros fill in behind the LSB
        if (sclkFall && (fallCnt_q < MAX_EDGES)) begin
            fallCnt_d = fallNext;
            outShift_d = {outShift_q[RES_BITS-2:0], 1'b0}; // RULE8
            dataOut_d = outShift_q[RES_BITS-2];
            if (fallNext == SAMPLE_EDGE && state_q == ST_IDLE) begin
                state_d = ST_SAMPLE; // RULE14
                sampleEn_d = 1'b1;
            end
            if (fallNext >= LAST_EDGE) begin
                dataOut_d = 1'b0; // RULE9
            end
            if (fallNext == LAST_EDGE && state_q == ST_SAMPLE) begin
                state_d = ST_CONV; // RULE15
                sampleEn_d = 1'b0;
                eoc_d = 1'b0; // RULE13
                dac_d = TRIAL_MSB;
                bitIdx_d = BIT_FIRST;
            end
        end

        // Too few clocks before select rose: no conversion starts
        if (!csActive && state_q == ST_SAMPLE) begin // RULE16
            state_d = ST_IDLE;
            sampleEn_d = 1'b0;
        end

        // Successive approximation, one bit per system clock
        unique case (state_q)
            ST_IDLE, ST_SAMPLE: begin
            end
            ST_CONV: begin
                if (!compHigh) begin
                    dac_d[bitIdx_q] = 1'b0;
                end
                if (bitIdx_q == BIT_LAST) begin
                    state_d = ST_DONE;
                end else begin
                    bitIdx_d = bitIdx_q - BIT_STEP;
                    dac_d[bitIdx_q - BIT_STEP] = 1'b1;
                end
            end
            ST_DONE: begin
                state_d = ST_IDLE;
                lastResult_d = dac_q;
                eoc_d = 1'b1; // RULE11
                // Select held low after exactly ten clocks: the next transfer opens on the rising end of conversion
                // A longer transfer may still be clocking here, so it keeps its zero fill rather than a reload
                if (csActive && fallCnt_q == LAST_EDGE) begin // RULE9
                    riseCnt_d = EDGE_ZERO;
                    fallCnt_d = EDGE_ZERO;
                    outShift_d = dac_q;
                    dataOut_d = dac_q[RES_BITS-1];
                end
            end
        endcase

        // Select falling restarts the transfer and shows the previous MSB at once
        if (csFall) begin // RULE4 RULE7
            state_d = ST_IDLE;
            riseCnt_d = EDGE_ZERO;
            fallCnt_d = EDGE_ZERO;
            addrShift_d = CODE_RST;
            sampleEn_d = 1'b0;
            eoc_d = 1'b1;
            outShift_d = lastResult_q;
            dataOut_d = lastResult_q[RES_BITS-1];
        end
    end

    // State registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= ST_IDLE;
            riseCnt_q <= EDGE_ZERO;
            fallCnt_q <= EDGE_ZERO;
            addrShift_q <= CODE_RST;
            chanCode_q <= CODE_RST;
            outShift_q <= RESULT_RST;
            lastResult_q <= RESULT_RST;
            dac_q <= RESULT_RST;
            bitIdx_q <= BIT_LAST;
            dataOut_q <= 1'b0;
            dataOutEn_q <= 1'b0;
            eoc_q <= 1'b1;
            sampleEn_q <= 1'b0;
        end else begin
            state_q <= state_d;
            riseCnt_q <= riseCnt_d;
            fallCnt_q <= fallCnt_d;
            addrShift_q <= addrShift_d;
            chanCode_q <= chanCode_d;
            outShift_q <= outShift_d;
            lastResult_q <= lastResult_d;
            dac_q <= dac_d;
            bitIdx_q <= bitIdx_d;
            dataOut_q <= dataOut_d;
            dataOutEn_q <= dataOutEn_d;
            eoc_q <= eoc_d;
            sampleEn_q <= sampleEn_d;
        end
    end

    // ------------------------------------------------------------
    // Input selector decode
    // ------------------------------------------------------------
    logic [CH_COUNT-1:0] sel_d, sel_q;

    // Codes past the last channel select nothing, which keeps the mux quiet
    genvar c;
    generate
        for (c = 0; c < CH_COUNT; c++) begin : gSel
            always_comb begin
                sel_d[c] = (chanCode_q == ADDR_BITS'(c)); // RULE10
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sel_q <= '0;
        end else begin
            sel_q <= sel_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs, all from flip-flops
    // ------------------------------------------------------------
    assign dataOut = dataOut_q;
    assign dataOutEn = dataOutEn_q; // RULE6
    assign endOfConv = eoc_q;
    assign sampleEn = sampleEn_q;
    assign analogSel = sel_q;
    assign dacTrial = dac_q;

endmodule

`default_nettype wire

// *** tb/sai_core_checker.sv ***
// Port assertions for the serial converter control block
`timescale 1ns/1ps
`default_nettype none
module sai_core_checker
    import sai_pkg::*;
#(
    parameter int CH_COUNT = NUM_CH
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic chipSelectN,
    input wire logic serialClock,
    input wire logic serialAddress,
    input wire logic compHigh,
    input wire logic dataOut,
    input wire logic dataOutEn,
    input wire logic endOfConv,
    input wire logic sampleEn,
    input wire logic [CH_COUNT-1:0] analogSel,
    input wire logic [RES_BITS-1:0] dacTrial
);
    // ------------------------------------------------------------
    // Relations between pins and outputs
    // ------------------------------------------------------------
    // Six cycles covers the synchroniser, filter and output register
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    oe_off_a: assert property (chipSelectN [*6] |-> !dataOutEn)
        else $error("result pin driven while deselected");
    oe_on_a: assert property (!chipSelectN [*6] |-> dataOutEn)
        else $error("result pin released while selected");
    eoc_fall_a: assert property ($fell(endOfConv) |-> $fell(sampleEn) && dacTrial == TRIAL_MSB)
        else $error("conversion start without end of sampling");
    eoc_rise_a: assert property ($fell(endOfConv) |-> ##[1:14] endOfConv)
        else $error("conversion did not finish in time");
    dout_low_a: assert property (!endOfConv && dataOutEn |-> !dataOut)
        else $error("result pin not low after tenth clock");
    sel_hot_a: assert property ($onehot0(analogSel))
        else $error("more than one input selected");
    sel_hold_a: assert property (sampleEn |-> $stable(analogSel))
        else $error("selection moved during sampling");
    sample_gate_a: assert property (sampleEn |-> dataOutEn)
        else $error("sampling while deselected");
    dac_hold_a: assert property (endOfConv && $past(endOfConv) |-> $stable(dacTrial))
        else $error("trial code moved while idle");
endmodule
`default_nettype wire

// *** tb/sai_host_model.sv ***
// Host serial port model that drives select, serial clock and address
`timescale 1ns/1ps
`default_nettype none
module sai_host_model
    import sai_pkg::*;
(
    input wire logic clk,
    input wire logic dataOut,
    output sai_pins_t pins,
    output logic [15:0] resWord,
    output logic resValid
);
    int seed = 66758;
    // Set by the bench to keep select low between transfers
    logic holdLow = 1'b0;
    // ------------------------------------------------------------
    // One transfer: pre idle clocks with select high, then n clocks
    // ------------------------------------------------------------
    // Half periods of four system clocks give the 800 ns serial clock
    task automatic xfer(input logic [3:0] code, input int n, input int pre);
        logic [15:0] w;
        w = 16'h0000;
        repeat (pre) begin
            pins.sclk = 1'b1;
            repeat (4) @(negedge clk);
            pins.sclk = 1'b0;
            repeat (4) @(negedge clk);
        end
        pins.csN = 1'b0;
        repeat (10) @(negedge clk);
        for (int i = 0; i < n; i++) begin
            pins.addr = (i < 4) ? code[3-i] : 1'($random(seed));
            repeat (4) @(negedge clk);
            pins.sclk = 1'b1;
            repeat (4) @(negedge clk);
            w = {w[14:0], dataOut};
            pins.sclk = 1'b0;
        end
        // Sampled late in the high phase: pin to output takes five cycles
        repeat (8) @(negedge clk);
        if (!holdLow) begin
            pins.csN = 1'b1;
        end
        pins.addr = ~pins.addr;
        resWord = w << (16 - n);
        resValid = 1'b1;
        @(negedge clk);
        resValid = 1'b0;
        repeat (9) @(negedge clk);
    endtask
    initial begin
        pins = PIN_RST;
        resWord = 16'h0000;
        resValid = 1'b0;
    end
endmodule
`default_nettype wire

// *** tb/sai_core_tb.sv ***
// Self-checking bench of the serial converter control block
`timescale 1ns/1ps
`default_nettype none
module sai_core_tb
    import sai_pkg::*;
;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic compHigh = 1'b0;
    logic dataOut, dataOutEn, endOfConv, sampleEn, resValid;
    logic [NUM_CH-1:0] analogSel;
    logic [RES_BITS-1:0] dacTrial, sv, prev;
    logic [RES_BITS-1:0] chVal [NUM_CH];
    logic [15:0] resWord;
    logic [15:0] expQ [$];
    sai_pins_t pins;
    int seed = 66758;
    int error_cnt = 0;
    int checks = 0;
    int n;
    int eocLowCnt = 0;
    logic pinData;
    always #50 clk = ~clk;
    // A released result pin reads as the inverse, so a missing enable shows up in the data
    assign pinData = dataOutEn ? dataOut : !dataOut;
    // Cycles spent converting, seen at the falling edge
    always @(negedge clk) if (endOfConv === 1'b0) eocLowCnt++;
    sai_core dut (.clk(clk), .resetn(resetn), .chipSelectN(pins.csN), .serialClock(pins.sclk),
        .serialAddress(pins.addr), .compHigh(compHigh), .dataOut(dataOut), .dataOutEn(dataOutEn),
        .endOfConv(endOfConv), .sampleEn(sampleEn), .analogSel(analogSel), .dacTrial(dacTrial));
    sai_host_model host (.clk(clk), .dataOut(pinData), .pins(pins), .resWord(resWord), .resValid(resValid));
    // ------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic results();
        $display("checks=%0d error_cnt=%0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Comparator: the selected input against the trial code, none selected reads as zero
    always @(negedge clk) begin
        sv = 10'h000;
        for (int k = 0; k < NUM_CH; k++) if (analogSel[k]) sv = chVal[k];
        compHigh <= (sv >= dacTrial);
    end
    // Oldest note is matched to each word the host gathered
    always @(posedge resValid) chk(resWord, expQ.pop_front());
    // One transfer; expected word is the previous result, top n bits only
    task automatic run(input logic [3:0] c, input int cnt, input int pre);
        int e0;
        e0 = eocLowCnt;
        expQ.push_back({prev, 6'h00} & ~(16'hFFFF >> cnt));
        host.xfer(c, cnt, pre);
        for (int t = 0; t < 40 && endOfConv !== 1'b1; t++) @(negedge clk);
        chk({15'h0000, endOfConv}, 16'h0001);
        chk(16'(eocLowCnt - e0), (cnt >= 10) ? 16'h000B : 16'h0000);
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        prev = RESULT_RST;
        for (int k = 0; k < NUM_CH; k++) chVal[k] = RES_BITS'($random(seed));
        repeat (3) @(negedge clk);
        resetn = 1'b1;
        chk({14'h0000, dataOutEn, endOfConv}, 16'h0001);
        for (int c = 0; c < 16; c++) begin
            n = 10 + $unsigned($random(seed)) % 7;
            run(c[3:0], n, c % 3);
            chk({2'b00, analogSel}, (c < NUM_CH) ? 16'h0001 << c : 16'h0000);
            prev = (c < NUM_CH) ? chVal[c] : 10'h000;
        end
        // Select raised after six clocks: no conversion, old result kept
        run(4'h5, 6, 2);
        chk({2'b00, analogSel}, 16'h0020);
        run(4'h2, 12, 0);
        prev = chVal[2];
        run(4'h0, 10, 0);
        prev = chVal[0];
        // Select held low across ten-clock transfers: the MSB reloads at end of conversion
        host.holdLow = 1'b1;
        run(4'h3, 10, 0);
        prev = chVal[3];
        run(4'h7, 10, 0);
        prev = chVal[7];
        host.holdLow = 1'b0;
        run(4'h1, 10, 0);
        chk({2'b00, analogSel}, 16'h0002);
        repeat (4) @(negedge clk);
        chk(16'(expQ.size()), 16'h0000);
        results();
    end
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        results();
    end
endmodule
bind sai_core sai_core_checker #(.CH_COUNT(CH_COUNT)) chk_i (.clk(clk), .resetn(resetn),
    .chipSelectN(chipSelectN), .serialClock(serialClock), .serialAddress(serialAddress),
    .compHigh(compHigh), .dataOut(dataOut), .dataOutEn(dataOutEn), .endOfConv(endOfConv),
    .sampleEn(sampleEn), .analogSel(analogSel), .dacTrial(dacTrial));
`default_nettype wire
